// ==== rtl/pfta_pkg.sv ====
// package: offsets, field layouts, reset values and types of the filter table window
package pfta_pkg;

	// ****************************************
	// register byte offsets within the port page
	// ****************************************
	localparam logic [11:0] OFF_ETYPE_LO   = 12'h609;
	localparam logic [11:0] OFF_PRIO_ACT   = 12'h60a;
	localparam logic [11:0] OFF_REMARK_MAP = 12'h60b;
	localparam logic [11:0] OFF_SPARE      = 12'h60c;
	localparam logic [11:0] OFF_FWD_PORTS  = 12'h60d;
	localparam logic [11:0] OFF_RULESET_HI = 12'h60e;
	localparam logic [11:0] OFF_RULESET_LO = 12'h60f;
	localparam logic [11:0] OFF_BSEL_HI    = 12'h610;
	localparam logic [11:0] OFF_BSEL_LO    = 12'h611;
	localparam logic [11:0] OFF_XFER_CTRL  = 12'h612;
	localparam logic [11:0] OFF_RING_POL   = 12'h613;

	// ****************************************
	// field positions and widths
	// ****************************************
	localparam int unsigned BYTE_W       = 8;
	localparam int unsigned ENTRY_BYTES  = 16;
	localparam int unsigned INDEX_W      = 4;
	localparam int unsigned HOLD_FIRST   = 9;  // first holding byte in this window
	localparam int unsigned PM_MSB       = 7;
	localparam int unsigned PM_LSB       = 6;
	localparam int unsigned PRIO_MSB     = 5;
	localparam int unsigned PRIO_LSB     = 3;
	localparam int unsigned RPE_BIT      = 2;
	localparam int unsigned RMK_HI_MSB   = 1;
	localparam int unsigned RMK_LO_BIT   = 7;
	localparam int unsigned MM_MSB       = 6;
	localparam int unsigned MM_LSB       = 5;
	localparam int unsigned FWD_MSB      = 6;
	localparam int unsigned WR_DONE_BIT  = 6;
	localparam int unsigned RD_DONE_BIT  = 5;
	localparam int unsigned DIR_BIT      = 4;
	localparam int unsigned POLICY_BIT   = 0;
	localparam int unsigned CTRL_RW_MASK_W = 5;

	// ****************************************
	// reset values and codes
	// ****************************************
	localparam logic [7:0] BYTE_RESET  = 8'h00;
	localparam logic       DONE_RESET  = 1'b1;
	localparam logic       DIR_WRITE   = 1'b1;
	localparam logic [1:0] FM_NONE     = 2'h0;
	localparam logic [1:0] FM_L2_MAC   = 2'h1;
	localparam logic [1:0] FM_L3_IP    = 2'h2;
	localparam logic [1:0] FM_L4_PORT  = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} pfta_bus_t;

	typedef struct packed {
		logic [3:0]  index;
		logic [15:0] bsel;   // bit k selects entry byte 15-k
		logic        write;
	} pfta_xfer_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MOVE = 2'b01,
		ST_DONE = 2'b11
	} pfta_state_t;

	// entry filter mode decoding
	typedef enum logic [1:0] {
		FMODE_NONE = 2'h0,
		FMODE_L2   = 2'h1,
		FMODE_L3   = 2'h2,
		FMODE_L4   = 2'h3
	} pfta_fmode_t;

endpackage : pfta_pkg

// ==== rtl/pfta_entry_mem.sv ====
// file: per-port table storage, sixteen entries of sixteen bytes
`timescale 1ns/1ns
module pfta_entry_mem #(
	parameter int unsigned ENTRIES = 16,
	parameter int unsigned BYTES   = 16
) (
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	input  wire logic [$clog2(ENTRIES)-1:0]   addr,
	input  wire logic                         we,
	input  wire logic [BYTES-1:0]             be,
	input  wire logic [BYTES*8-1:0]           wdata,
	output      logic [BYTES*8-1:0]           rdata
);
	import pfta_pkg::*;

	logic [BYTES*8-1:0] mem_q [ENTRIES];

	// ****************************************
	// byte-masked write port
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (we) begin
			for (int b = 0; b < BYTES; b++) begin
				if (be[b]) begin
					mem_q[addr][b*8 +: 8] <= wdata[b*8 +: 8];
				end
			end
		end
	end

	// registered read data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem_q[addr];
		end
	end

endmodule : pfta_entry_mem

// ==== rtl/pfta_reset_sync.sv ====
// file: reset release synchroniser
`timescale 1ns/1ns
module pfta_reset_sync (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	output      logic rst_n
);
	logic meta_q;

	// async assert, two-flop release
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			meta_q <= 1'b1;
			rst_n  <= meta_q;
		end
	end

endmodule : pfta_reset_sync

// ==== rtl/pfta_top.sv ====
// file: filter table indirect access window, upper holding bytes and control
// How it works
// - remark priority: bits 2:1 in byte A bits 1:0, bit 0 in byte B bit 7.
// - byte A holds priority mode 7:6, priority 5:3, remark enable bit 2.
// - forward map bits 6:0; bit i enables forwarding to port i+1.
// - high select bit 0 picks holding byte 7, bit 7 picks byte 0.
// - low select bit 0 picks holding byte F, bit 7 picks byte 8.
// - only a write to the low select register starts a transfer.
// - only selected bytes move between table and holding registers.
// - write-done flag bit 6 low while writing, high when done, resets high.
// - policy one: ring frames use one entry, a match counts as miss.
// - policy zero: ring frames use many entries, ruleset match is hit.
// - filter mode 00 none, 01 L2 MAC, 10 L3 IP, 11 L4 port.
// - each port owns its table, reached only through these registers.
`timescale 1ns/1ns
module pfta_top (
	input  wire logic                 clk_sys,
	input  wire logic                 reset_n,
	input  wire pfta_pkg::pfta_bus_t  bus,
	output      logic [7:0]           rdata,
	output      logic                 ring_single_entry,
	output      logic                 ring_match_is_miss,
	output      logic [6:0]           fwd_port_map,
	output      logic [1:0]           entry_filter_mode
);
	import pfta_pkg::*;

	logic              rst_n;
	logic [7:0]        hold_q [ENTRY_BYTES];
	logic [15:0]       bsel_q;
	logic              dir_q;
	logic [3:0]        index_q;
	logic              wr_done_q;
	logic              rd_done_q;
	logic              policy_q;
	pfta_xfer_t        xfer_q;
	pfta_state_t       state_q;
	logic              mem_we;
	logic [127:0]      mem_wdata;
	logic [127:0]      mem_rdata;
	logic [15:0]       mem_be;
	logic              start;
	logic              wr_hold;

	// byte k of the flat word is holding byte k
	function automatic logic [15:0] sel_to_bytes(input logic [15:0] sel);
		logic [15:0] r;
		r = '0;
		for (int k = 0; k < ENTRY_BYTES; k++) begin
			r[k] = sel[ENTRY_BYTES-1-k];
		end
		return r;
	endfunction : sel_to_bytes

	// software offset to holding byte number
	function automatic logic [3:0] off_to_byte(input logic [11:0] off);
		return off[3:0];
	endfunction : off_to_byte

	pfta_reset_sync u_rst (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.rst_n   (rst_n)
	);

	// ****************************************
	// start decode
	// ****************************************
	// low select only
	assign start   = bus.wr && (bus.addr == OFF_BSEL_LO)
		&& (state_q == ST_IDLE);
	assign wr_hold = bus.wr && (bus.addr >= OFF_ETYPE_LO)
		&& (bus.addr <= OFF_RULESET_LO) && (bus.addr != OFF_SPARE);

	// ****************************************
	// byte select registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bsel_q <= '0;
		end else if (bus.wr && bus.addr == OFF_BSEL_HI) begin
			bsel_q[15:8] <= bus.wdata;
		end else if (bus.wr && bus.addr == OFF_BSEL_LO) begin
			bsel_q[7:0] <= bus.wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dir_q   <= 1'b0;
			index_q <= '0;
		end else if (bus.wr && bus.addr == OFF_XFER_CTRL) begin
			dir_q   <= bus.wdata[DIR_BIT];
			index_q <= bus.wdata[INDEX_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			policy_q <= 1'b0;
		end else if (bus.wr && bus.addr == OFF_RING_POL) begin
			policy_q <= bus.wdata[POLICY_BIT];
		end
	end

	// ****************************************
	// transfer sequencer
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			xfer_q  <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q      <= ST_MOVE;
						xfer_q.index <= index_q;
						xfer_q.write <= dir_q;
						xfer_q.bsel  <= {bsel_q[15:8], bus.wdata};
					end
				end
				ST_MOVE: state_q <= ST_DONE;
				ST_DONE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign mem_be = sel_to_bytes(xfer_q.bsel);
	assign mem_we = (state_q == ST_MOVE) && xfer_q.write;
	always_comb begin
		mem_wdata = '0;
		for (int k = 0; k < ENTRY_BYTES; k++) begin
			mem_wdata[k*8 +: 8] = hold_q[k];
		end
	end

	pfta_entry_mem #(
		.ENTRIES (2**INDEX_W),
		.BYTES   (ENTRY_BYTES)
	) u_mem (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.addr    (xfer_q.index),
		.we      (mem_we),
		.be      (mem_be),
		.wdata   (mem_wdata),
		.rdata   (mem_rdata)
	);

	// ****************************************
	// completion flags
	// ****************************************
	// write done, cleared at start
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_done_q <= DONE_RESET;
			rd_done_q <= DONE_RESET;
		end else begin
			if (start && dir_q == DIR_WRITE) begin
				wr_done_q <= 1'b0;
			end else if (state_q == ST_DONE && xfer_q.write) begin
				wr_done_q <= 1'b1;
			end
			if (start && dir_q != DIR_WRITE) begin
				rd_done_q <= 1'b0;
			end else if (state_q == ST_DONE && !xfer_q.write) begin
				rd_done_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// holding bytes
	// ****************************************
	// software writes, then masked read-back from table
	// remark split kept
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < ENTRY_BYTES; k++) begin
				hold_q[k] <= BYTE_RESET;
			end
		end else if (state_q == ST_DONE && !xfer_q.write) begin
			for (int k = 0; k < ENTRY_BYTES; k++) begin
				if (mem_be[k]) begin
					hold_q[k] <= mem_rdata[k*8 +: 8];
				end
			end
		end else if (wr_hold) begin
			hold_q[off_to_byte(bus.addr)] <= bus.wdata;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (bus.rd) begin
			case (bus.addr)
				OFF_ETYPE_LO, OFF_PRIO_ACT, OFF_REMARK_MAP,
				OFF_FWD_PORTS, OFF_RULESET_HI, OFF_RULESET_LO:
					rdata <= hold_q[off_to_byte(bus.addr)];
				OFF_SPARE:     rdata <= BYTE_RESET;
				OFF_BSEL_HI:   rdata <= bsel_q[15:8];
				OFF_BSEL_LO:   rdata <= bsel_q[7:0];
				OFF_XFER_CTRL: rdata <= {1'b0, wr_done_q, rd_done_q,
					dir_q, index_q};
				OFF_RING_POL:  rdata <= {7'h00, policy_q};
				default:       rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

	// ****************************************
	// outputs to the matching engine
	// ****************************************
	// forward map, ring hit mode
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fwd_port_map       <= '0;
			ring_single_entry  <= 1'b0;
			ring_match_is_miss <= 1'b0;
			entry_filter_mode  <= FM_NONE;
		end else begin
			fwd_port_map       <= hold_q[OFF_FWD_PORTS[3:0]][FWD_MSB:0];
			ring_single_entry  <= policy_q;
			ring_match_is_miss <= policy_q;
			entry_filter_mode  <= hold_q[1][5:4];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	property p_wr_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		(start && dir_q) |=> !wr_done_q;
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("write flag stayed");

	property p_wr_done;
		@(posedge clk_sys) disable iff (!rst_n)
		(start && dir_q) |=> !wr_done_q ##2 wr_done_q;
	endproperty
	a_wr_done: assert property (p_wr_done) else $error("write never done");

	property p_rd_done;
		@(posedge clk_sys) disable iff (!rst_n)
		(start && !dir_q) |=> !rd_done_q ##2 rd_done_q;
	endproperty
	a_rd_done: assert property (p_rd_done) else $error("read never done");

	property p_hi_no_start;
		@(posedge clk_sys) disable iff (!rst_n)
		(bus.wr && bus.addr == OFF_BSEL_HI && state_q == ST_IDLE)
			|=> state_q == ST_IDLE;
	endproperty
	a_hi_no_start: assert property (p_hi_no_start) else $error("hi started");

	property p_masked;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_DONE && !xfer_q.write && !mem_be[15])
			|=> $stable(hold_q[15]);
	endproperty
	a_masked: assert property (p_masked) else $error("masked byte moved");

	property p_policy;
		@(posedge clk_sys) disable iff (!rst_n)
		ring_match_is_miss == $past(policy_q);
	endproperty
	a_policy: assert property (p_policy) else $error("policy lag");

	property p_fwd;
		@(posedge clk_sys) disable iff (!rst_n)
		fwd_port_map == $past(hold_q[13][6:0]);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward map wrong");

	property p_map;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_IDLE && start) |=> xfer_q.bsel[7:0] == $past(bus.wdata);
	endproperty
	a_map: assert property (p_map) else $error("low select lost");

	// high select bit 0 must reach byte 7 and bit 7 byte 0
	property p_hi_map;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_MOVE) |-> (mem_be[7] == xfer_q.bsel[8])
			&& (mem_be[0] == xfer_q.bsel[15]);
	endproperty
	a_hi_map: assert property (p_hi_map) else $error("hi map");

	c_write: cover property (@(posedge clk_sys) start && dir_q);
	c_read:  cover property (@(posedge clk_sys) start && !dir_q);
	c_pol:   cover property (@(posedge clk_sys) policy_q);

endmodule : pfta_top

// ==== testbench/tb_top.sv ====
// testbench: register access and table transfers of the filter table window
`timescale 1ns/1ns
module tb_top;
	import pfta_pkg::*;

	// ****************************************
	// signals and counters
	// ****************************************
	logic              clk_sys;
	logic              reset_n;
	pfta_bus_t         bus;
	logic [7:0]        rdata;
	logic              ring_single_entry;
	logic              ring_match_is_miss;
	logic [6:0]        fwd_port_map;
	logic [1:0]        entry_filter_mode;
	int                err_count;
	int                tests_run;

	// device under test
	pfta_top i_dut (
		.clk_sys            (clk_sys),
		.reset_n            (reset_n),
		.bus                (bus),
		.rdata              (rdata),
		.ring_single_entry  (ring_single_entry),
		.ring_match_is_miss (ring_match_is_miss),
		.fwd_port_map       (fwd_port_map),
		.entry_filter_mode  (entry_filter_mode)
	);

	// 50 MHz clock
	always #10 clk_sys = ~clk_sys;

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic chk(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask : wr_reg

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk($sformatf("reg_%h", a), exp, d);
	endtask : rd_chk

	// start a transfer, see the flag drop at once, then poll it back
	task automatic xfer(input logic [7:0] ctrl, input logic [7:0] sel,
			input int bitn);
		logic [7:0] s;
		int         n;
		wr_reg(OFF_XFER_CTRL, ctrl);
		@(posedge clk_sys);
		bus <= '{addr: OFF_BSEL_LO, wdata: sel, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus <= '{addr: OFF_XFER_CTRL, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 chk("done_low", 8'h00, rdata & (8'h01 << bitn));
		n = 0;
		do begin
			rd_reg(OFF_XFER_CTRL, s);
			n++;
		end while (s[bitn] !== 1'b1 && n < 20);
		chk("status_after", {3'b011, ctrl[4:0]}, s);
	endtask : xfer

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset_values();
		logic [11:0] a;
		for (int i = 9; i <= 19; i++) begin
			a = 12'h600 + 12'(i);
			rd_chk(a, (a == OFF_XFER_CTRL) ? 8'h60 : 8'h00);
		end
		rd_chk(12'h600, 8'h00);
		chk("ring_out", 8'h00, {6'h00, ring_single_entry,
			ring_match_is_miss});
	endtask : t_reset_values

	// field readback, spare byte ignored, high select does not start
	task automatic t_fields();
		logic [11:0] ta [8];
		logic [7:0]  tw [8];
		logic [7:0]  te [8];
		ta = '{OFF_ETYPE_LO, OFF_PRIO_ACT, OFF_REMARK_MAP, OFF_SPARE,
			OFF_FWD_PORTS, OFF_RULESET_HI, OFF_RULESET_LO, OFF_BSEL_HI};
		tw = '{8'hc3, 8'hd5, 8'hc0, 8'h5a, 8'h7f, 8'ha5, 8'h3c, 8'h81};
		te = '{8'hc3, 8'hd5, 8'hc0, 8'h00, 8'h7f, 8'ha5, 8'h3c, 8'h81};
		wr_reg(OFF_XFER_CTRL, 8'h05);
		for (int i = 0; i < 8; i++) begin
			wr_reg(ta[i], tw[i]);
			rd_chk(ta[i], te[i]);
		end
		rd_chk(OFF_XFER_CTRL, 8'h65);
		chk("fwd_map", 8'h7f, {1'b0, fwd_port_map});
		wr_reg(OFF_FWD_PORTS, 8'h2a);
		@(posedge clk_sys);
		#1 chk("fwd_map", 8'h2a, {1'b0, fwd_port_map});
		wr_reg(OFF_RING_POL, 8'h01);
		rd_chk(OFF_RING_POL, 8'h01);
		chk("ring_out", 8'h03, {6'h00, ring_single_entry,
			ring_match_is_miss});
		wr_reg(OFF_RING_POL, 8'h00);
		rd_chk(OFF_RING_POL, 8'h00);
		chk("ring_out", 8'h00, {6'h00, ring_single_entry,
			ring_match_is_miss});
		// high select left at 0x81 so transfers also drive bytes 0 and 7
		rd_chk(OFF_BSEL_LO, 8'h00);
	endtask : t_fields

	// fill holding bytes 9..f except spare byte c with base+byte, or with zero when base is 0
	task automatic fill(input logic [7:0] base);
		for (int b = 9; b < 16; b++) begin
			wr_reg(12'h600 + 12'(b), (base == 8'h00) ? 8'h00 : base + 8'(b));
		end
	endtask : fill

	// two entries written, partial and full read back
	task automatic t_transfer();
		logic [7:0] exp;
		fill(8'h20);
		xfer(8'h13, 8'h7f, 6);
		fill(8'h40);
		xfer(8'h14, 8'h7f, 6);
		fill(8'h00);
		// select bits 1 and 2 pick bytes e and d only, f must stay put
		xfer(8'h03, 8'h06, 5);
		for (int b = 9; b < 16; b++) begin
			exp = (b == 14 || b == 13) ? 8'h20 + 8'(b) : 8'h00;
			rd_chk(12'h600 + 12'(b), exp);
		end
		xfer(8'h04, 8'h7f, 5);
		for (int b = 9; b < 16; b++) begin
			exp = (b == 12) ? 8'h00 : 8'h40 + 8'(b);
			rd_chk(12'h600 + 12'(b), exp);
		end
		chk("fwd_map", 8'h4d, {1'b0, fwd_port_map});
		chk("filter_mode", 8'h00, {6'h00, entry_filter_mode});
	endtask : t_transfer

	// ****************************************
	// closing and main sequence
	// ****************************************
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	// watchdog against a hung poll
	initial begin
		#100000;
		err_count++;
		$display("MISMATCH watchdog expected finish seen hang");
		wrap_up();
	end

	initial begin
		clk_sys   = 1'b0;
		reset_n   = 1'b0;
		bus       = '0;
		err_count = 0;
		tests_run = 0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset_values();
		t_fields();
		t_transfer();
		wrap_up();
	end

endmodule : tb_top
